/* File: design/acp_host.sv */
// Host end: link clock divider, conversion sequencing and result buffer
`timescale 1ns/1ps
module acp_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);

   logic [W-1:0]             mem [D];
   logic [AW:0]              wr_ff;
   logic [AW:0]              rd_ff;
   logic [AW:0]              nxt_wr;
   logic [AW:0]              nxt_rd;
   logic                     ov_ff;
   logic                     nxt_ov;
   logic [W-1:0]             od_ff;
   logic [W-1:0]             nxt_od;
   logic                     full;
   logic                     empty;
   logic                     push;

   assign full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   assign empty = (wr_ff == rd_ff);
   assign push  = in_valid_i & ~full;

   // Output stage is a register so the consumer sees flop-driven data
   always_comb begin
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = rd_ff;
      nxt_ov = ov_ff;
      nxt_od = od_ff;
      if ((!ov_ff || out_ready_i) && !empty) begin
         nxt_ov = 1'b1;
         nxt_od = mem[rd_ff[AW-1:0]];
         nxt_rd = rd_ff + 1'b1;
      end else if (out_ready_i) begin
         nxt_ov = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         ov_ff <= 1'b0;
         od_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         ov_ff <= nxt_ov;
         od_ff <= nxt_od;
      end
   end

   assign in_ready_o  = ~full;
   assign out_valid_o = ov_ff;
   assign out_data_o  = od_ff;
endmodule : acp_fifo

module acp_host #(
   parameter int unsigned WAKE_CYC = acp_pkg::WAKE_CYC_DEF
) (
   acp_link_if.host                     lnk,
   input  wire logic                    ref_clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    enable_i,
   input  wire logic [acp_pkg::CMD_W-1:0] cfg_i,
   output logic                         busy_o,
   output logic                         asleep_o,
   output logic                         waking_o,
   output logic                         res_valid_o,
   input  wire logic                    res_ready_i,
   output logic [15:0]                  res_data_o
);

   acp_pkg::acp_hst_state_t state_ff;
   acp_pkg::acp_hst_state_t nxt_state;
   logic [1:0]              div_ff;
   logic [1:0]              nxt_div;
   logic                    sck_ff;
   logic                    nxt_sck;
   logic                    cs_ff;
   logic                    nxt_cs;
   logic                    sdi_ff;
   logic                    nxt_sdi;
   logic                    sdo_m_ff;
   logic                    sdo_s_ff;
   logic [19:0]             wait_ff;
   logic [19:0]             nxt_wait;
   logic [4:0]              rise_ff;
   logic [4:0]              nxt_rise;
   logic [15:0]             cmd_ff;
   logic [15:0]             nxt_cmd;
   logic [15:0]             res_ff;
   logic [15:0]             nxt_res;
   logic                    asleep_ff;
   logic                    nxt_asleep;
   logic                    busy_ff;
   logic                    waking_ff;
   logic                    frame_slp_ff;
   logic                    nxt_frame_slp;
   logic                    push;
   logic                    fifo_ready;
   logic                    rise_edge;
   logic                    fall_edge;

   // Link clock runs free: it is the only clock the converter has
   assign rise_edge = (div_ff == acp_pkg::PH_RISE);
   assign fall_edge = (div_ff == acp_pkg::PH_FALL);
   assign nxt_div   = div_ff + 2'h1;
   assign nxt_sck   = (nxt_div < acp_pkg::PH_HIGH);

   always_comb begin
      nxt_state  = state_ff;
      nxt_cs     = cs_ff;
      nxt_sdi    = sdi_ff;
      nxt_wait   = wait_ff;
      nxt_rise   = rise_ff;
      nxt_cmd    = cmd_ff;
      nxt_res    = res_ff;
      nxt_asleep = asleep_ff;
      push       = 1'b0;
      unique case (state_ff)
         acp_pkg::ACP_HST_IDLE: begin
            // Start only with room for the result; a full buffer stalls conversions
            if (enable_i && fifo_ready && fall_edge) begin
               nxt_state = acp_pkg::ACP_HST_HOLD;
               nxt_cs    = 1'b1;
               nxt_wait  = acp_pkg::HOLD_CYC - 20'h1;
               nxt_cmd   = {cfg_i, {(16 - acp_pkg::CMD_W){1'b0}}};
            end
         end
         acp_pkg::ACP_HST_HOLD: begin
            // Select stays high past conversion end; sdi stays quiet meanwhile while the link clock keeps running
            if (wait_ff != 20'h0) begin
               nxt_wait = wait_ff - 20'h1;
            end else if (fall_edge) begin
               nxt_state = acp_pkg::ACP_HST_FRAME;
               nxt_cs    = 1'b0;
               nxt_rise  = 5'h00;
            end
         end
         acp_pkg::ACP_HST_FRAME: begin
            if (rise_edge) begin
               nxt_rise = rise_ff + 5'h01;
            end
            if (fall_edge && rise_ff != 5'h00 && rise_ff <= acp_pkg::SDI_LAST_RISE) begin
               nxt_sdi = cmd_ff[15];
               nxt_cmd = {cmd_ff[14:0], 1'b0};
            end
            if (div_ff == acp_pkg::PH_SAMPLE && rise_ff >= acp_pkg::SDO_FIRST_RISE
                && rise_ff <= acp_pkg::SDO_LAST_RISE) begin
               nxt_res = {res_ff[14:0], sdo_s_ff};
            end
            if (fall_edge && rise_ff == acp_pkg::FRAME_END_RISE) begin
               push       = 1'b1;
               nxt_sdi    = 1'b0;
               nxt_asleep = frame_slp_ff;
               if (asleep_ff && !frame_slp_ff) begin
                  nxt_state = acp_pkg::ACP_HST_WAKE;
                  nxt_wait  = 20'(WAKE_CYC - 1);
               end else begin
                  nxt_state = acp_pkg::ACP_HST_IDLE;
               end
            end
         end
         acp_pkg::ACP_HST_WAKE: begin
            if (wait_ff == 20'h0) begin
               nxt_state = acp_pkg::ACP_HST_IDLE;
            end else begin
               nxt_wait = wait_ff - 20'h1;
            end
         end
      endcase
   end

   // Sleep bit of the word just sent, held in the frame register until reload
   assign nxt_frame_slp = (state_ff == acp_pkg::ACP_HST_IDLE) ? cfg_i[0] : frame_slp_ff;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff     <= acp_pkg::ACP_HST_IDLE;
         div_ff       <= 2'h0;
         sck_ff       <= 1'b0;
         cs_ff        <= 1'b0;
         sdi_ff       <= 1'b0;
         sdo_m_ff     <= 1'b0;
         sdo_s_ff     <= 1'b0;
         wait_ff      <= 20'h0;
         rise_ff      <= 5'h00;
         cmd_ff       <= 16'h0000;
         res_ff       <= 16'h0000;
         asleep_ff    <= 1'b0;
         frame_slp_ff <= 1'b0;
         busy_ff      <= 1'b0;
         waking_ff    <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         div_ff       <= nxt_div;
         sck_ff       <= nxt_sck;
         cs_ff        <= nxt_cs;
         sdi_ff       <= nxt_sdi;
         sdo_m_ff     <= lnk.sdo;
         sdo_s_ff     <= sdo_m_ff;
         wait_ff      <= nxt_wait;
         rise_ff      <= nxt_rise;
         cmd_ff       <= nxt_cmd;
         res_ff       <= nxt_res;
         asleep_ff    <= nxt_asleep;
         frame_slp_ff <= nxt_frame_slp;
         busy_ff      <= (nxt_state != acp_pkg::ACP_HST_IDLE);
         waking_ff    <= (nxt_state == acp_pkg::ACP_HST_WAKE);
      end
   end

   acp_fifo #(
      .W (acp_pkg::FIFO_W),
      .D (acp_pkg::FIFO_D)
   ) u_fifo (
      .clk_i       (ref_clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_ready),
      .in_data_i   (res_ff),
      .out_valid_o (res_valid_o),
      .out_ready_i (res_ready_i),
      .out_data_o  (res_data_o)
   );

   assign lnk.sck                 = sck_ff;
   assign lnk.chip_select_convert = cs_ff;
   assign lnk.sdi                 = sdi_ff;
   assign busy_o                  = busy_ff;
   assign asleep_o                = asleep_ff;
   assign waking_o                = waking_ff;

endmodule : acp_host

/* File: common/acp_pkg.sv */
// Shared constants and types for the converter control link
package acp_pkg;

   // Clock plan: the host divides its reference clock to make the link clock
   localparam int REF_PERIOD_NS  = 100;
   localparam int LINK_DIV       = 4;
   localparam int LINK_PERIOD_NS = REF_PERIOD_NS * LINK_DIV;

   // Conversion time, longest figure, rounded down to link cycles
   localparam int CONV_MAX_NS    = 3500;
   localparam int CONV_CYC_RAW   = CONV_MAX_NS / LINK_PERIOD_NS;
   localparam logic [3:0] CONV_CYC = 4'((CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW);

   // Select may only fall this soon after a start; shorter than a link period, so unused
   localparam int CS_EARLY_NS    = 100;

   // Synchroniser depth plus the cycle in which the state machine reacts
   localparam int SYNC_LAT       = 3;
   localparam logic [19:0] HOLD_CYC = 20'((CONV_CYC_RAW + SYNC_LAT + 1) * LINK_DIV);

   // Wake-up delay after sleep is left
   localparam int WAKE_MS        = 60;
   localparam int WAKE_CYC_DEF   = WAKE_MS * 1000000 / REF_PERIOD_NS;

   // Divider phases of the host, counter value before the edge
   localparam logic [1:0] PH_RISE   = 2'h3;
   localparam logic [1:0] PH_FALL   = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_HIGH   = 2'h2;

   // Frame layout, counted in link rises after select falls
   localparam int FRAME_BITS     = 16;
   localparam logic [4:0] SDI_LAST_RISE  = 5'h10;
   localparam logic [4:0] SDO_FIRST_RISE = 5'h03;
   localparam logic [4:0] SDO_LAST_RISE  = 5'h12;
   localparam logic [4:0] FRAME_END_RISE = 5'h14;
   localparam logic [3:0] LAST_BIT       = 4'hf;

   // Input word, first bit sent lands in bit 15
   localparam int CMD_W          = 7;
   localparam int MUX_HI         = 15;
   localparam int MUX_LO         = 11;
   localparam int UNI_POS        = 10;
   localparam int SLP_POS        = 9;

   // Result buffer in the host
   localparam int FIFO_W         = 16;
   localparam int FIFO_D         = 8;

   typedef enum logic [1:0] {
      ACP_DEV_ACQ   = 2'b00,
      ACP_DEV_CONV  = 2'b01,
      ACP_DEV_NAP   = 2'b10,
      ACP_DEV_SHIFT = 2'b11
   } acp_dev_state_t;

   typedef enum logic [1:0] {
      ACP_HST_IDLE  = 2'b00,
      ACP_HST_HOLD  = 2'b01,
      ACP_HST_FRAME = 2'b10,
      ACP_HST_WAKE  = 2'b11
   } acp_hst_state_t;

endpackage : acp_pkg

/* File: common/acp_link_if.sv */
// Serial link between the converter and its host
`timescale 1ns/1ps
interface acp_link_if;
   logic sck;
   logic chip_select_convert;
   logic sdi;
   logic sdo;

   modport dev (
      input  sck,
      input  chip_select_convert,
      input  sdi,
      output sdo
   );

   modport host (
      output sck,
      output chip_select_convert,
      output sdi,
      input  sdo
   );
endinterface : acp_link_if

/* File: design/acp_device.sv */
// Converter end: conversion trigger, nap and sleep control, serial port
//
// Function
// - Rising select edge starts a conversion
// - Edges during conversion are ignored
// - Select high at conversion end enters nap
// - Nap keeps only reference voltages powered
// - Select low at end: MSB out, stay powered
// - Host lowers select early or after end
// - Sleep bit set in word enters sleep
// - Host waits wake-up delay after sleep
// - Host keeps serial lines steady while converting (sck still runs free through the conversion)
// - Host avoids other bus traffic while converting
// - Conversion finishes within longest conversion time
// - Select low shifts result, format by mode
`timescale 1ns/1ps
module acp_device (
   acp_link_if.dev         lnk,
   input  wire logic       rstn_i,
   input  wire logic [15:0] sample_i,
   output logic            busy_o,
   output logic            nap_o,
   output logic            sleep_o,
   output logic            ref_on_o,
   output logic            core_on_o,
   output logic            unipolar_o,
   output logic [4:0]      mux_cfg_o,
   output logic [15:0]     result_o,
   output logic            result_valid_o
);

   // Link inputs arrive from the host clock domain
   logic                   cs_m_ff;
   logic                   cs_s_ff;
   logic                   cs_d_ff;
   logic                   sdi_m_ff;
   logic                   sdi_s_ff;
   logic                   cs_rise;

   acp_pkg::acp_dev_state_t state_ff;
   acp_pkg::acp_dev_state_t nxt_state;
   logic [3:0]             cnt_ff;
   logic [3:0]             nxt_cnt;
   logic [3:0]             bit_ff;
   logic [3:0]             nxt_bit;
   logic [15:0]            data_ff;
   logic [15:0]            nxt_data;
   logic [15:0]            out_sr_ff;
   logic [15:0]            nxt_out_sr;
   logic [15:0]            in_sr_ff;
   logic [15:0]            nxt_in_sr;
   logic [15:0]            word;
   logic                   sdo_ff;
   logic                   nxt_sdo;
   logic                   sleep_ff;
   logic                   nxt_sleep;
   logic                   uni_ff;
   logic                   nxt_uni;
   logic [4:0]             mux_ff;
   logic [4:0]             nxt_mux;
   logic [15:0]            result_ff;
   logic [15:0]            nxt_result;
   logic                   rvalid_ff;
   logic                   nxt_rvalid;
   logic                   busy_ff;
   logic                   nap_ff;
   logic                   ref_on_ff;
   logic                   core_on_ff;
   logic                   nxt_busy;
   logic                   nxt_nap;
   logic                   nxt_ref_on;
   logic                   nxt_core_on;

   always_ff @(posedge lnk.sck or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_m_ff  <= 1'b0;
         cs_s_ff  <= 1'b0;
         cs_d_ff  <= 1'b0;
         sdi_m_ff <= 1'b0;
         sdi_s_ff <= 1'b0;
      end else begin
         cs_m_ff  <= lnk.chip_select_convert;
         cs_s_ff  <= cs_m_ff;
         cs_d_ff  <= cs_s_ff;
         sdi_m_ff <= lnk.sdi;
         sdi_s_ff <= sdi_m_ff;
      end
   end

   assign cs_rise = cs_s_ff & ~cs_d_ff;
   assign word    = {in_sr_ff[14:0], sdi_s_ff};

   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_bit    = bit_ff;
      nxt_data   = data_ff;
      nxt_out_sr = out_sr_ff;
      nxt_in_sr  = in_sr_ff;
      nxt_sdo    = sdo_ff;
      nxt_sleep  = sleep_ff;
      nxt_uni    = uni_ff;
      nxt_mux    = mux_ff;
      nxt_result = result_ff;
      nxt_rvalid = 1'b0;
      unique case (state_ff)
         acp_pkg::ACP_DEV_ACQ: begin
            if (cs_rise) begin
               // Sample is held from here; straight binary or offset two's complement
               nxt_state = acp_pkg::ACP_DEV_CONV;
               nxt_cnt   = acp_pkg::CONV_CYC - 4'h1;
               nxt_data  = uni_ff ? sample_i : {~sample_i[15], sample_i[14:0]};
            end
         end
         acp_pkg::ACP_DEV_CONV: begin
            // Select edges are not looked at until the count expires
            if (cnt_ff == 4'h0) begin
               nxt_out_sr = {data_ff[14:0], 1'b0};
               nxt_bit    = 4'h0;
               nxt_result = data_ff;
               nxt_rvalid = 1'b1;
               if (cs_s_ff) begin
                  nxt_state = acp_pkg::ACP_DEV_NAP;
               end else begin
                  nxt_state = acp_pkg::ACP_DEV_SHIFT;
                  nxt_sdo   = data_ff[15];
               end
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         acp_pkg::ACP_DEV_NAP: begin
            // Select falling is the activity that wakes the port
            if (!cs_s_ff) begin
               nxt_state = acp_pkg::ACP_DEV_SHIFT;
               nxt_sdo   = data_ff[15];
            end
         end
         acp_pkg::ACP_DEV_SHIFT: begin
            if (cs_rise) begin
               // A new start abandons the rest of the frame
               nxt_state = acp_pkg::ACP_DEV_CONV;
               nxt_cnt   = acp_pkg::CONV_CYC - 4'h1;
               nxt_data  = uni_ff ? sample_i : {~sample_i[15], sample_i[14:0]};
            end else if (!cs_s_ff) begin
               nxt_sdo    = out_sr_ff[15];
               nxt_out_sr = {out_sr_ff[14:0], 1'b0};
               nxt_in_sr  = word;
               nxt_bit    = bit_ff + 4'h1;
               if (bit_ff == acp_pkg::LAST_BIT) begin
                  nxt_state = acp_pkg::ACP_DEV_ACQ;
                  nxt_sleep = word[acp_pkg::SLP_POS];
                  nxt_uni   = word[acp_pkg::UNI_POS];
                  nxt_mux   = word[acp_pkg::MUX_HI:acp_pkg::MUX_LO];
               end
            end
         end
      endcase
   end

   // Power status follows the state being entered, so it is never a cycle late
   always_comb begin
      nxt_busy    = (nxt_state == acp_pkg::ACP_DEV_CONV);
      nxt_nap     = (nxt_state == acp_pkg::ACP_DEV_NAP);
      nxt_ref_on  = ~nxt_sleep;
      nxt_core_on = ~nxt_sleep & (nxt_state != acp_pkg::ACP_DEV_NAP);
   end

   always_ff @(posedge lnk.sck or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff   <= acp_pkg::ACP_DEV_ACQ;
         cnt_ff     <= 4'h0;
         bit_ff     <= 4'h0;
         data_ff    <= 16'h0000;
         out_sr_ff  <= 16'h0000;
         in_sr_ff   <= 16'h0000;
         sdo_ff     <= 1'b0;
         sleep_ff   <= 1'b0;
         uni_ff     <= 1'b0;
         mux_ff     <= 5'h00;
         result_ff  <= 16'h0000;
         rvalid_ff  <= 1'b0;
         busy_ff    <= 1'b0;
         nap_ff     <= 1'b0;
         ref_on_ff  <= 1'b1;
         core_on_ff <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         bit_ff     <= nxt_bit;
         data_ff    <= nxt_data;
         out_sr_ff  <= nxt_out_sr;
         in_sr_ff   <= nxt_in_sr;
         sdo_ff     <= nxt_sdo;
         sleep_ff   <= nxt_sleep;
         uni_ff     <= nxt_uni;
         mux_ff     <= nxt_mux;
         result_ff  <= nxt_result;
         rvalid_ff  <= nxt_rvalid;
         busy_ff    <= nxt_busy;
         nap_ff     <= nxt_nap;
         ref_on_ff  <= nxt_ref_on;
         core_on_ff <= nxt_core_on;
      end
   end

   assign lnk.sdo        = sdo_ff;
   assign busy_o         = busy_ff;
   assign nap_o          = nap_ff;
   assign sleep_o        = sleep_ff;
   assign ref_on_o       = ref_on_ff;
   assign core_on_o      = core_on_ff;
   assign unipolar_o     = uni_ff;
   assign mux_cfg_o      = mux_ff;
   assign result_o       = result_ff;
   assign result_valid_o = rvalid_ff;

endmodule : acp_device

/* File: verification/acp_link_chk.sv */
// Assertions on the link and the converter end's state outputs
`timescale 1ns/1ps
module acp_link_chk (
   input wire logic sck,
   input wire logic chip_select_convert,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic rstn_i,
   input wire logic busy_o,
   input wire logic nap_o,
   input wire logic sleep_o,
   input wire logic ref_on_o,
   input wire logic core_on_o,
   input wire logic result_valid_o
);
   default clocking cb @(posedge sck); endclocking
   default disable iff (!rstn_i);

   logic [4:0] conv_cnt_ff;
   logic [4:0] nxt_conv_cnt;

   always_comb begin
      nxt_conv_cnt = busy_o ? conv_cnt_ff + 5'h01 : 5'h00;
   end

   always_ff @(posedge sck or negedge rstn_i) begin
      if (!rstn_i) begin
         conv_cnt_ff <= 5'h00;
      end else begin
         conv_cnt_ff <= nxt_conv_cnt;
      end
   end

   sequence s_start;
      $rose(chip_select_convert) && !busy_o;
   endsequence
   sequence s_end_high;
      $fell(busy_o) && chip_select_convert;
   endsequence
   sequence s_pulse;
      result_valid_o ##1 !result_valid_o;
   endsequence

   a_start_on_rise: assert property (s_start |-> ##[1:3] busy_o)
      else $error("conversion did not start after select rose");
   a_no_restart: assert property ($rose(busy_o) |-> busy_o[*8] ##1 !busy_o)
      else $error("conversion length wrong");
   a_conv_time_max: assert property (conv_cnt_ff <= 5'h08)
      else $error("conversion too long");
   a_conv_end_pulse: assert property ($fell(busy_o) |-> ##[0:1] s_pulse)
      else $error("no single result pulse at conversion end");
   a_nap_entry: assert property (s_end_high |-> ##[0:1] nap_o)
      else $error("no nap with select high at end");
   a_nap_power: assert property (nap_o && !sleep_o |-> ref_on_o && !core_on_o)
      else $error("wrong power state in nap");
   a_sleep_power: assert property (sleep_o |-> !ref_on_o && !core_on_o)
      else $error("wrong power state in sleep");
   a_port_enable: assert property ($fell(chip_select_convert) && nap_o |-> ##[1:4] !nap_o)
      else $error("nap not left when select fell");
   a_sdi_steady: assert property (busy_o && $past(busy_o) |-> $stable(sdi))
      else $error("serial input moved during conversion");
   a_sdo_steady: assert property (busy_o && $past(busy_o) |-> $stable(sdo))
      else $error("serial output moved during conversion");
   a_late_select_drop: assert property ($fell(chip_select_convert) |-> !busy_o)
      else $error("select dropped while converting");
endmodule : acp_link_chk

/* File: verification/acp_link_test.sv */
// Self-checking bench: host and converter joined over the link
`timescale 1ns/1ps
module acp_link_test;
   typedef struct {logic [15:0] v; bit care;} acp_note_t;
   logic        ref_clk_i, rstn_i, dev_rstn, enable_i, res_ready_i;
   logic [6:0]  cfg_i;
   logic [15:0] sample_i, res_data, result;
   logic        h_busy, asleep, waking, res_valid;
   logic        busy, nap, sleep, ref_on, core_on, unipolar, res_pulse;
   logic [4:0]  mux_cfg;
   bit          pulse_seen;
   acp_note_t   notes[$];
   acp_note_t   n;
   int          mismatches, check_count, stable_cnt, cyc, pulses, k, ready_mode;
   integer      seed = 82470;

   acp_link_if lnk ();
   acp_host #(.WAKE_CYC(20)) i_acp_host (.lnk(lnk), .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .enable_i(enable_i), .cfg_i(cfg_i), .busy_o(h_busy), .asleep_o(asleep),
      .waking_o(waking), .res_valid_o(res_valid), .res_ready_i(res_ready_i),
      .res_data_o(res_data));
   acp_device i_acp_device (.lnk(lnk), .rstn_i(dev_rstn), .sample_i(sample_i), .busy_o(busy),
      .nap_o(nap), .sleep_o(sleep), .ref_on_o(ref_on), .core_on_o(core_on),
      .unipolar_o(unipolar), .mux_cfg_o(mux_cfg), .result_o(result),
      .result_valid_o(res_pulse));
   acp_link_chk i_acp_link_chk (.sck(lnk.sck), .chip_select_convert(lnk.chip_select_convert),
      .sdi(lnk.sdi), .sdo(lnk.sdo), .rstn_i(dev_rstn), .busy_o(busy), .nap_o(nap),
      .sleep_o(sleep), .ref_on_o(ref_on), .core_on_o(core_on), .result_valid_o(res_pulse));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // Counts conversions after a word change; mode takes a frame or two to land
   task automatic wait_conv(input int cnt);
      k = 0;
      while (stable_cnt < cnt && k < 4000) begin
         @(negedge ref_clk_i);
         k++;
      end
      check(16'(stable_cnt >= cnt), 16'h0001);
   endtask : wait_conv

   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         give_verdict();
      end
   end

   // Note taken once per end pulse, before the sample moves on; bipolar flips the sign bit
   always @(negedge ref_clk_i) begin
      if (dev_rstn && res_pulse && !pulse_seen) begin
         n.v = cfg_i[1] ? sample_i : sample_i ^ 16'h8000;
         n.care = stable_cnt >= 3 && !sleep && !cfg_i[0];
         notes.push_back(n);
         if (n.care) check(result, n.v);
         stable_cnt++;
         pulses++;
         sample_i <= 16'($random(seed));
      end
      pulse_seen = dev_rstn && res_pulse;
      res_ready_i <= (ready_mode == 2) ? 1'b1 : (ready_mode == 1) ? 1'($random(seed)) : 1'b0;
   end

   always @(posedge ref_clk_i) begin
      if (res_valid && res_ready_i) begin
         if (notes.size() == 0) begin
            check(16'h0000, 16'h0001);
         end else begin
            n = notes.pop_front();
            if (n.care) check(res_data, n.v);
         end
      end
   end

   initial begin
      rstn_i = 1'b0;
      dev_rstn = 1'b0;
      enable_i = 1'b0;
      cfg_i = 7'h02;
      sample_i = 16'h0000;
      res_ready_i = 1'b0;
      ready_mode = 1;
      repeat (10) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      repeat (16) @(negedge ref_clk_i);
      dev_rstn = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      enable_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         cfg_i = {5'($random(seed)), i[0], 1'b0};
         stable_cnt = 0;
         wait_conv(5);
         check(16'(unipolar), 16'(cfg_i[1]));
         check(16'(mux_cfg), 16'(cfg_i[6:2]));
      end
      $display("Test format and mux done");
      ready_mode = 0;
      // Nine words fill buffer and output stage at about 135 cycles each
      repeat (2000) @(negedge ref_clk_i);
      pulses = 0;
      repeat (3000) @(negedge ref_clk_i);
      check(16'(res_valid), 16'h0001);
      check(16'(pulses <= 2), 16'h0001);
      check(16'(h_busy), 16'h0000);
      ready_mode = 1;
      stable_cnt = 3;
      wait_conv(14);
      $display("Test full buffer done");
      cfg_i[0] = 1'b1;
      stable_cnt = 0;
      k = 0;
      while (sleep !== 1'b1 && k < 4000) begin
         @(negedge ref_clk_i);
         k++;
      end
      // Host flags sleep only at frame end, a few cycles after the converter
      repeat (8) @(negedge ref_clk_i);
      check(16'({sleep, ref_on, core_on, asleep}), 16'h0009);
      cfg_i[0] = 1'b0;
      k = 0;
      while (waking !== 1'b1 && k < 4000) begin
         @(negedge ref_clk_i);
         k++;
      end
      check(16'(waking), 16'h0001);
      k = 0;
      while (sleep !== 1'b0 && k < 4000) begin
         @(negedge ref_clk_i);
         k++;
      end
      check(16'({sleep, ref_on, core_on}), 16'h0003);
      stable_cnt = 0;
      wait_conv(6);
      $display("Test sleep and wake done");
      give_verdict();
   end
endmodule : acp_link_test
